// >>> rtl/sls_device_end.sv
// receive port of the streaming link core: one output slot with back-pressure
// assumes upstream deframer, status bits and reset sequencer share sys_clk
`timescale 1ns/1ps
`default_nettype none
module sls_device_end
  import sls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sls_sink_if.dev snk,
  input wire logic initDone,
  input wire logic burstMode,
  input wire logic advancedClocking,
  input wire logic eccEnable,
  input wire logic [sls_pkg::DATA_W-1:0] upData,
  input wire logic upValid,
  output logic upReady,
  input wire logic upFirst,
  input wire logic upLast,
  input wire logic [sls_pkg::SIDE_W-1:0] upSideband,
  input wire logic [sls_pkg::SIDE_W-1:0] upInvalidWords,
  input wire logic [sls_pkg::LANES-1:0] upCrcErr,
  input wire logic upAlignLoss,
  input wire logic upOverflow,
  input wire logic upSeuFixed,
  input wire logic upSeuFatal,
  input wire logic [sls_pkg::IRQ_W-1:0] errStatus,
  input wire logic [sls_pkg::IRQ_W-1:0] errIrqEnable
);
  import sls_pkg::*;

  typedef struct packed {
    logic linkReady;
    logic valid;
    logic [DATA_W-1:0] data;
    logic [SIDE_W-1:0] sideband;
    logic first;
    logic last;
    logic [ERR_W-1:0] error;
    logic irq;
    logic seenFirst;
  } sls_dev_s;

  sls_dev_s cur;
  sls_dev_s next_cur;
  logic pop;
  logic take;

  // builds the error word for one accepted beat
  function automatic logic [ERR_W-1:0] slsErrWord(
    input logic [LANES-1:0] crc,
    input logic align,
    input logic ovf,
    input logic seuFix,
    input logic seuBad,
    input logic adv,
    input logic ecc
  );
    logic [ERR_W-1:0] w;
    w = ERR_RST;
    w[LANES-1:0] = crc;
    w[ERR_ALIGN] = align;
    w[ERR_TIED] = 1'b0;
    // upper bits driven low where they mean nothing, so stale junk never leaks
    if (!adv)
    begin
      w[ERR_OVF] = ovf;
      if (ecc)
      begin
        w[ERR_SEU_FIX] = seuFix;
        w[ERR_SEU_BAD] = seuBad;
      end
    end
    // advanced clocking leaves overflow and upset bits at zero
    return w;
  endfunction

  // in burst mode, sideband at the end of a burst carries the count of unused lane words
  function automatic logic [SIDE_W-1:0] slsSideWord(
    input logic lastBeat,
    input logic [SIDE_W-1:0] remote,
    input logic [SIDE_W-1:0] invalidWords
  );
    logic [SIDE_W-1:0] s;
    s = remote;
    if (lastBeat)
    begin
      if (LANES == 1)
      begin
        s = SIDE_SINGLE_LANE_END;
      end
      else
      begin
        s = invalidWords;
      end
    end
    return s;
  endfunction

  // zero accept latency: a held word leaves in the cycle ready is seen high
  assign pop = cur.valid && snk.ready;
  // limitation: upReady follows ready combinationally to keep full rate
  assign upReady = cur.linkReady && (!cur.valid || snk.ready);
  assign take = upValid && upReady;

  always_comb
  begin
    next_cur = cur;
    next_cur.linkReady = initDone;
    // interrupt is a level: high while any enabled status bit stands
    next_cur.irq = |(errStatus & errIrqEnable);
    if (pop)
    begin
      next_cur.valid = 1'b0;
    end
    if (take)
    begin
      next_cur.valid = 1'b1;
      next_cur.data = upData;
      next_cur.last = upLast;
      if (burstMode)
      begin
        next_cur.first = upFirst;
      end
      else
      begin
        // whole stream is one burst: only the very first word is marked
        next_cur.first = !cur.seenFirst;
      end
      next_cur.seenFirst = 1'b1;
      next_cur.sideband = slsSideWord(upLast && burstMode, upSideband, upInvalidWords);
      next_cur.error = slsErrWord(upCrcErr, upAlignLoss, upOverflow, upSeuFixed,
        upSeuFatal, advancedClocking, eccEnable);
    end
    else if (pop)
    begin
      // markers and errors cleared with valid so they never linger
      next_cur.first = 1'b0;
      next_cur.last = 1'b0;
      next_cur.error = ERR_RST;
    end
    if (!initDone)
    begin
      // losing initialization restarts continuous-mode first marking
      next_cur.valid = 1'b0;
      next_cur.first = 1'b0;
      next_cur.last = 1'b0;
      next_cur.error = ERR_RST;
      next_cur.seenFirst = 1'b0;
    end
  end

  // every stream output below changes only on sys_clk or on the asynchronous rst
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur.linkReady <= 1'b0;
      cur.valid <= 1'b0;
      cur.data <= DATA_RST;
      cur.sideband <= SIDE_RST;
      cur.first <= 1'b0;
      cur.last <= 1'b0;
      cur.error <= ERR_RST;
      cur.irq <= 1'b0;
      cur.seenFirst <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign snk.linkReady = cur.linkReady;
  assign snk.valid = cur.valid;
  assign snk.data = cur.data;
  assign snk.sideband = cur.sideband;
  assign snk.burstFirstFlag = cur.first;
  assign snk.burstLastFlag = cur.last;
  assign snk.error = cur.error;
  assign snk.errIrq = cur.irq;

  // data and sideband are held while valid waits for ready, so a
  // consumer that stalls sees a stable word; the slot frees in the same
  // cycle it drains, which is what allows a back-to-back stream.
  // the consumer is trusted to hold ready across a burst; a drop
  // mid-burst only stalls here, nothing is lost or repeated.
  // when link ready is low the consumer throws the beat away.

endmodule
`default_nettype wire

// >>> rtl/sls_pkg.sv
// constants shared by both ends of the streaming receive port
// assumes one system clock and a fixed lane count
package sls_pkg;
  localparam int LANES = 2;
  localparam int LANE_W = 64;
  localparam int DATA_W = LANE_W * LANES;
  localparam int SIDE_W = 8;
  localparam int ERR_W = LANES + 5;
  localparam int ERR_ALIGN = LANES;
  localparam int ERR_TIED = LANES + 1;
  localparam int ERR_OVF = LANES + 2;
  localparam int ERR_SEU_FIX = LANES + 3;
  localparam int ERR_SEU_BAD = LANES + 4;
  localparam int IRQ_W = 8;
  localparam int ACCEPT_LATENCY = 0;
  localparam logic [SIDE_W-1:0] SIDE_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = '0;
  localparam logic [ERR_W-1:0] ERR_RST = '0;
  localparam logic [SIDE_W-1:0] SIDE_SINGLE_LANE_END = 8'h00;
endpackage

// >>> rtl/sls_sink_if.sv
// interface joining the receive port of the link core and its consumer
// assumes both ends run on the same sys_clk
`timescale 1ns/1ps
`default_nettype none
interface sls_sink_if;
  import sls_pkg::*;
  logic linkReady;
  logic [DATA_W-1:0] data;
  logic [SIDE_W-1:0] sideband;
  logic valid;
  logic burstFirstFlag;
  logic burstLastFlag;
  logic [ERR_W-1:0] error;
  logic ready;
  logic errIrq;
  modport dev (
    output linkReady, data, sideband, valid, burstFirstFlag, burstLastFlag, error, errIrq,
    input ready
  );
  modport usr (
    input linkReady, data, sideband, valid, burstFirstFlag, burstLastFlag, error, errIrq,
    output ready
  );
endinterface
`default_nettype wire

// >>> rtl/sls_user_end.sv
// consumer of the streaming receive port
// assumes the core's port and this logic share sys_clk
`timescale 1ns/1ps
`default_nettype none
module sls_user_end
  import sls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sls_sink_if.usr snk,
  input wire logic wantReady,
  input wire logic advancedClocking,
  output logic wordStrobe,
  output logic [sls_pkg::DATA_W-1:0] wordData,
  output logic wordFirst,
  output logic wordLast,
  output logic [sls_pkg::SIDE_W-1:0] wordSideband,
  output logic [sls_pkg::ERR_W-1:0] wordError,
  output logic irqSeen
);
  import sls_pkg::*;

  typedef struct packed {
    logic ready;
    logic inBurst;
    logic strobe;
    logic [DATA_W-1:0] data;
    logic first;
    logic last;
    logic [SIDE_W-1:0] sideband;
    logic [ERR_W-1:0] error;
    logic irq;
  } sls_usr_s;

  sls_usr_s cur;
  sls_usr_s next_cur;
  logic xfer;
  logic openBurst;

  // accepted in the same cycle that ready is high; beats with link down dropped
  assign xfer = snk.valid && cur.ready && snk.linkReady;

  always_comb
  begin
    next_cur = cur;
    next_cur.strobe = xfer;
    next_cur.irq = snk.errIrq;
    openBurst = cur.inBurst;
    if (xfer)
    begin
      if (snk.burstFirstFlag)
      begin
        openBurst = 1'b1;
      end
      if (snk.burstLastFlag)
      begin
        openBurst = 1'b0;
      end
      next_cur.data = snk.data;
      next_cur.first = snk.burstFirstFlag;
      next_cur.last = snk.burstLastFlag;
      next_cur.sideband = snk.sideband;
      next_cur.error = snk.error;
      if (advancedClocking)
      begin
        // upper error bits carry nothing in this clocking
        next_cur.error[ERR_SEU_BAD:ERR_OVF] = 3'h0;
      end
    end
    if (!snk.linkReady)
    begin
      openBurst = 1'b0;
    end
    next_cur.inBurst = openBurst;
    // ready may only fall between bursts, never inside one
    next_cur.ready = openBurst || wantReady;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur.ready <= 1'b0;
      cur.inBurst <= 1'b0;
      cur.strobe <= 1'b0;
      cur.data <= DATA_RST;
      cur.first <= 1'b0;
      cur.last <= 1'b0;
      cur.sideband <= SIDE_RST;
      cur.error <= ERR_RST;
      cur.irq <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign snk.ready = cur.ready;
  assign wordStrobe = cur.strobe;
  assign wordData = cur.data;
  assign wordFirst = cur.first;
  assign wordLast = cur.last;
  assign wordSideband = cur.sideband;
  assign wordError = cur.error;
  assign irqSeen = cur.irq;
endmodule
`default_nettype wire

// >>> tb/sls_sink_properties.sv
// sink link checker: stall holds, idle flags, ready within a burst
// assumes one clock, signals taken straight off the interface
`timescale 1ns/1ps
`default_nettype none
module sls_sink_properties
  import sls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linkReady,
  input wire logic [sls_pkg::DATA_W-1:0] data,
  input wire logic [sls_pkg::SIDE_W-1:0] sideband,
  input wire logic valid,
  input wire logic burstFirstFlag,
  input wire logic burstLastFlag,
  input wire logic [sls_pkg::ERR_W-1:0] error,
  input wire logic ready
);
  import sls_pkg::*;
  logic inBurst;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // open burst, forgotten when the link drops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      inBurst <= 1'b0;
    else if (!linkReady)
      inBurst <= 1'b0;
    else if (valid && ready)
      inBurst <= (inBurst || burstFirstFlag) && !burstLastFlag;
  end
  a_data_held: assert property (valid && !ready |=> valid && $stable(data))
    else $error("data moved while stalled");
  a_side_held: assert property (valid && !ready |=> $stable(sideband) && $stable(burstLastFlag))
    else $error("sideband or last moved while stalled");
  a_first_held: assert property (valid && !ready |=> $stable(burstFirstFlag) && $stable(error))
    else $error("first or error moved while stalled");
  a_stall_twice: assert property ((valid && !ready) [*2] |=> valid)
    else $error("beat lost during stall");
  a_tied_zero: assert property (valid |-> error[ERR_TIED] == 1'b0)
    else $error("tied error bit set");
  a_link_first: assert property ($rose(valid) |-> $past(linkReady))
    else $error("beat before link ready");
  a_idle_clear: assert property (!valid |-> !burstFirstFlag && !burstLastFlag && error == '0)
    else $error("flags without valid");
  a_burst_ready: assert property (inBurst && linkReady |-> ready)
    else $error("ready dropped inside burst");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// bench: device end and user end joined by the sink interface
// assumes upstream feed and consumer wishes are driven from here
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sls_pkg::*;
  logic sys_clk, rst, initDone, burstMode, advancedClocking, eccEnable, upValid, upReady;
  logic upFirst, upLast, upAlignLoss, upOverflow, upSeuFixed, upSeuFatal, wantReady;
  logic wordStrobe, wordFirst, wordLast, irqSeen, contFirst;
  logic [DATA_W-1:0] upData, wordData;
  logic [SIDE_W-1:0] upSideband, upInvalidWords, wordSideband;
  logic [LANES-1:0] upCrcErr;
  logic [IRQ_W-1:0] errStatus, errIrqEnable;
  logic [ERR_W-1:0] wordError;
  logic [1:0] irqPipe;
  logic [DATA_W+SIDE_W+ERR_W+1:0] expQ[$];
  logic [DATA_W+SIDE_W+ERR_W+1:0] got;
  int fails, compares, n;
  assign got = {wordData, wordFirst, wordLast, wordSideband, wordError};
  sls_sink_if snk();
  sls_device_end u_sls_device_end(.sys_clk, .rst, .snk, .initDone, .burstMode,
    .advancedClocking, .eccEnable, .upData, .upValid, .upReady, .upFirst, .upLast,
    .upSideband, .upInvalidWords, .upCrcErr, .upAlignLoss, .upOverflow, .upSeuFixed,
    .upSeuFatal, .errStatus, .errIrqEnable);
  sls_user_end u_sls_user_end(.sys_clk, .rst, .snk, .wantReady, .advancedClocking,
    .wordStrobe, .wordData, .wordFirst, .wordLast, .wordSideband, .wordError, .irqSeen);
  sls_sink_properties u_sls_sink_properties(.sys_clk, .rst, .linkReady(snk.linkReady),
    .data(snk.data), .sideband(snk.sideband), .valid(snk.valid), .ready(snk.ready),
    .burstFirstFlag(snk.burstFirstFlag), .burstLastFlag(snk.burstLastFlag), .error(snk.error));
  task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] seen);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick_or_quit;
    @(negedge sys_clk);
    n++;
    if (n > 60)
    begin
      chk("wait bound", 1'h0, 1'h1);
      report_and_stop;
    end
  endtask
  // random beat, consumer stalls at random until it is taken
  task automatic send_beat;
    @(negedge sys_clk);
    upData = {$urandom, $urandom, $urandom, $urandom};
    {upFirst, upLast, upCrcErr, upAlignLoss, upOverflow, upSeuFixed, upSeuFatal} = 8'($urandom);
    upSideband = 8'($urandom);
    upInvalidWords = 8'($urandom % LANES);
    errStatus = 8'(1 << ($urandom % 16));
    errIrqEnable = 8'($urandom);
    // consumer wish changes per beat so stalls and held words really occur
    wantReady = 1'($urandom);
    upValid = 1'b1;
    n = 0;
    #1;
    while (upReady !== 1'b1)
    begin
      tick_or_quit();
      wantReady = 1'($urandom);
      #1;
    end
    @(posedge sys_clk);
  endtask
  // note the word at the edge where upstream hands it over
  always @(posedge sys_clk)
  begin
    if (!initDone)
      contFirst <= 1'b1;
    else if (!rst && upValid && upReady)
    begin
      expQ.push_back({upData, burstMode ? upFirst : contFirst, upLast,
        (burstMode && upLast) ? upInvalidWords : upSideband,
        {upSeuFatal, upSeuFixed} & {2{eccEnable && !advancedClocking}},
        upOverflow && !advancedClocking, 1'b0, upAlignLoss, upCrcErr});
      contFirst <= contFirst && burstMode;
    end
  end
  always @(posedge sys_clk)
  begin
    if (rst)
      irqPipe <= '0;
    else
    begin
      chk("irqSeen", irqPipe[1], irqSeen);
      irqPipe <= {irqPipe[0], |(errStatus & errIrqEnable)};
      if (wordStrobe && expQ.size() == 0)
        chk("extra word", 1'h0, 1'h1);
      else if (wordStrobe)
        chk("word", expQ.pop_front(), got);
    end
  end
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    void'($urandom(32'h809C));
    {rst, initDone, burstMode, advancedClocking, eccEnable, upValid, wantReady} = 7'h40;
    {upFirst, upLast, upCrcErr, upAlignLoss, upOverflow, upSeuFixed, upSeuFatal} = 8'h00;
    {upData, upSideband, upInvalidWords, errStatus, errIrqEnable} = '0;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    upValid = 1'b1;
    wantReady = 1'b1;
    repeat (4)
    begin
      @(negedge sys_clk);
      chk("upReady", 1'h0, upReady);
    end
    // each of the 8 mode settings gets a fresh link, drained before it drops
    for (int ph = 0; ph < 8; ph++)
    begin
      @(negedge sys_clk);
      upValid = 1'b0;
      initDone = 1'b0;
      repeat (3) @(negedge sys_clk);
      {burstMode, advancedClocking, eccEnable} = 3'(ph);
      initDone = 1'b1;
      repeat (30) send_beat();
      @(negedge sys_clk);
      upValid = 1'b0;
      wantReady = 1'b1;
      n = 0;
      while (expQ.size() != 0)
        tick_or_quit();
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
